// ===== common/pic_pkg.sv
// Types shared by the priority interrupt unit
package pic_pkg;
    typedef enum logic [1:0] {PIC_RUN, PIC_WANT_TYPE, PIC_WANT_CASC, PIC_WANT_MODE} pic_init_e;
    typedef struct packed {
        logic       addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pic_bus_s;
endpackage

// ===== common/pic_regs.svh
// Offsets, field positions, reset values and encodings of the priority interrupt unit
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
// Port offsets (address bit)
`define PIC_ADDR_CMD      1'b0
`define PIC_ADDR_DATA     1'b1
// First init word fields
`define PIC_FIW_MARK      4
`define PIC_FIW_NEED4     0
`define PIC_FIW_SINGLE    1
`define PIC_FIW_LEVEL     3
// Command word discrimination on the command port
`define PIC_OCW_SEL3      3
// Fourth init word fields
`define PIC_FOW_AEOI      1
`define PIC_FOW_SFN       4
// Read select command word fields
`define PIC_RSC_SPECIAL_MASK_ENABLE_BIT      6
`define PIC_RSC_SMM       5
`define PIC_RSC_POLL      2
`define PIC_RSC_RR        1
`define PIC_RSC_RIS       0
// End-of-service command codes, bits 7:5
`define PIC_EOS_NONSPEC   3'h1
`define PIC_EOS_SPEC      3'h3
`define PIC_EOS_ROT_NS    3'h5
`define PIC_EOS_ROT_AEOI  3'h4
`define PIC_EOS_CLR_AEOI  3'h0
`define PIC_EOS_ROT_SP    3'h7
`define PIC_EOS_SETPRI    3'h6
// Reset values and the bit of the poll flag
`define PIC_RST_LOWEST    3'h7
`define PIC_RST_MASK      8'h00
`define PIC_RST_TYPE      5'h00
`define PIC_POLL_FLAG     7
`endif

// ===== rtl/pic_unit.sv
// Eight-input programmable priority interrupt unit with command-word register port
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"

module pic_unit #(
    parameter int NUM_IN = 8
) (
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    input  wire pic_pkg::pic_bus_s   bus_in,
    input  wire logic [NUM_IN-1:0]   req_in,
    input  wire logic                ack_in,
    output logic [7:0]               rd_data_out,
    output logic                     int_out,
    output logic [7:0]               vector_out,
    output logic                     vector_valid_out,
    output logic [NUM_IN-1:0]        cascade_map_out
);
    import pic_pkg::*;

    // ******************************************************************
    // Helpers
    // ******************************************************************

    // Rank of a level under the current rotation; 0 is the highest
    function automatic logic [2:0] rank_of(input logic [2:0] lvl, input logic [2:0] low);
        rank_of = lvl - low - 3'h1;
    endfunction

    // Highest-ranked set bit of a vector, with a found flag
    function automatic logic [3:0] top_of(input logic [7:0] vec, input logic [2:0] low);
        logic [2:0] idx;
        top_of = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            idx = low + 3'h1 + 3'(i);
            if (vec[idx])
            begin
                top_of = {1'b1, idx};
            end
        end
    endfunction

    // ******************************************************************
    // State
    // ******************************************************************
    pic_init_e  init_state;
    logic       ready;
    logic       need_fourth;
    logic       single;
    logic       level_mode;
    logic       aeoi;
    logic       sfn;
    logic       rot_aeoi;
    logic       special_mask_select_bit;
    logic       poll_armed;
    logic       read_isr;
    logic [4:0] type_base;
    logic [2:0] lowest;
    logic [7:0] pending_request_register;
    logic [7:0] in_service_register;
    logic [7:0] request_mask_register;
    logic [7:0] casc;
    logic [7:0] req_meta;
    logic [7:0] req_sync;
    logic [7:0] req_prev;

    logic       wr_cmd;
    logic       wr_data;
    logic       is_fiw;
    logic       is_eos;
    logic       is_rsc;
    logic       poll_rd;
    logic       take;
    logic [3:0] win;
    logic [3:0] top;
    logic       win_ok;
    logic [2:0] win_lvl;
    logic       better;
    logic [7:0] isr_eff;
    logic [7:0] irr_set;
    logic [2:0] eos_code;
    logic [2:0] ns_lvl;

    // ******************************************************************
    // Command decode and priority resolution
    // ******************************************************************

    // Init words on the data port only while the sequence is open
    assign wr_cmd   = bus_in.wr && bus_in.addr == `PIC_ADDR_CMD;
    assign wr_data  = bus_in.wr && bus_in.addr == `PIC_ADDR_DATA;
    assign is_fiw   = wr_cmd && bus_in.wdata[`PIC_FIW_MARK];
    assign is_eos   = wr_cmd && !bus_in.wdata[`PIC_FIW_MARK] && !bus_in.wdata[`PIC_OCW_SEL3];
    assign is_rsc   = wr_cmd && !bus_in.wdata[`PIC_FIW_MARK] && bus_in.wdata[`PIC_OCW_SEL3];
    assign eos_code = bus_in.wdata[7:5];
    assign poll_rd  = bus_in.rd && bus_in.addr == `PIC_ADDR_CMD && poll_armed;

    // Masked in-service levels drop out of nesting under special mask
    assign isr_eff = special_mask_select_bit ? (in_service_register & ~request_mask_register) : in_service_register;
    assign win     = top_of(pending_request_register & ~request_mask_register, lowest);
    assign top     = top_of(isr_eff, lowest);
    assign win_lvl = win[2:0];
    assign ns_lvl  = top[2:0];

    // Strictly higher wins; equal only for a cascaded input in special nesting
    assign better = !top[3]
                 || rank_of(win_lvl, lowest) < rank_of(top[2:0], lowest)
                 || (sfn && win_lvl == top[2:0] && casc[win_lvl]);
    assign win_ok = ready && win[3] && better;
    assign take   = (ack_in || poll_rd) && win_ok;

    // ******************************************************************
    // Initialization sequence and mode bits
    // ******************************************************************

    // Two words alone, three with subordinates or when the fourth is asked for, four with both
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            init_state  <= PIC_RUN;
            ready       <= 1'b0;
            need_fourth <= 1'b0;
            single      <= 1'b1;
            level_mode  <= 1'b0;
            aeoi        <= 1'b0;
            sfn         <= 1'b0;
            type_base   <= `PIC_RST_TYPE;
            casc        <= 8'h00;
        end
        else if (is_fiw)
        begin
            init_state  <= PIC_WANT_TYPE;
            ready       <= 1'b0;
            need_fourth <= bus_in.wdata[`PIC_FIW_NEED4];
            single      <= bus_in.wdata[`PIC_FIW_SINGLE];
            level_mode  <= bus_in.wdata[`PIC_FIW_LEVEL];
            aeoi        <= 1'b0;
            sfn         <= 1'b0;
        end
        else if (wr_data)
        begin
            case (init_state)
                PIC_WANT_TYPE:
                begin
                    type_base <= bus_in.wdata[7:3];
                    if (!single)
                    begin
                        init_state <= PIC_WANT_CASC;
                    end
                    else if (need_fourth)
                    begin
                        init_state <= PIC_WANT_MODE;
                    end
                    else
                    begin
                        init_state <= PIC_RUN;
                        ready      <= 1'b1;
                    end
                end
                PIC_WANT_CASC:
                begin
                    casc <= bus_in.wdata;
                    if (need_fourth)
                    begin
                        init_state <= PIC_WANT_MODE;
                    end
                    else
                    begin
                        init_state <= PIC_RUN;
                        ready      <= 1'b1;
                    end
                end
                PIC_WANT_MODE:
                begin
                    aeoi       <= bus_in.wdata[`PIC_FOW_AEOI];
                    sfn        <= bus_in.wdata[`PIC_FOW_SFN];
                    init_state <= PIC_RUN;
                    ready      <= 1'b1;
                end
                default:
                begin
                    init_state <= PIC_RUN;
                end
            endcase
        end
    end

    // Read select, poll and special mask; select persists across reads
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || is_fiw)
        begin
            special_mask_select_bit        <= 1'b0;
            poll_armed <= 1'b0;
            read_isr   <= 1'b0;
        end
        else if (is_rsc)
        begin
            if (bus_in.wdata[`PIC_RSC_SPECIAL_MASK_ENABLE_BIT])
            begin
                special_mask_select_bit <= bus_in.wdata[`PIC_RSC_SMM];
            end
            if (bus_in.wdata[`PIC_RSC_RR])
            begin
                read_isr <= bus_in.wdata[`PIC_RSC_RIS];
            end
            poll_armed <= bus_in.wdata[`PIC_RSC_POLL];
        end
        else if (bus_in.rd && bus_in.addr == `PIC_ADDR_CMD)
        begin
            poll_armed <= 1'b0; // Poll is one read only
        end
    end

    // ******************************************************************
    // Rotation and mask
    // ******************************************************************

    // Lowest level sets the ranking; 7 gives plain fixed order
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || is_fiw)
        begin
            lowest   <= `PIC_RST_LOWEST;
            rot_aeoi <= 1'b0;
        end
        else if (is_eos && eos_code == `PIC_EOS_ROT_NS && top[3])
        begin
            lowest <= ns_lvl;
        end
        else if (is_eos && (eos_code == `PIC_EOS_ROT_SP || eos_code == `PIC_EOS_SETPRI))
        begin
            lowest <= bus_in.wdata[2:0];
        end
        else if (is_eos && eos_code == `PIC_EOS_ROT_AEOI)
        begin
            rot_aeoi <= 1'b1;
        end
        else if (is_eos && eos_code == `PIC_EOS_CLR_AEOI)
        begin
            rot_aeoi <= 1'b0;
        end
        else if (take && aeoi && rot_aeoi)
        begin
            lowest <= win_lvl;
        end
    end

    // Mask cleared by the first init word, then written on the data port
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || is_fiw)
        begin
            request_mask_register <= `PIC_RST_MASK;
        end
        else if (wr_data && init_state == PIC_RUN)
        begin
            request_mask_register <= bus_in.wdata;
        end
    end

    // ******************************************************************
    // Request capture
    // ******************************************************************

    // Two flops before any logic looks at the pins
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            req_meta <= 8'h00;
            req_sync <= 8'h00;
            req_prev <= 8'h00;
        end
        else
        begin
            req_meta <= req_in;
            req_sync <= req_meta;
            req_prev <= req_sync;
        end
    end

    // Level mode follows the line; edge mode latches a rise
    assign irr_set = level_mode ? req_sync : (req_sync & ~req_prev);

    // A new request wins over the acknowledge clear of the same bit
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || is_fiw)
        begin
            pending_request_register <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (irr_set[i])
                begin
                    pending_request_register[i] <= 1'b1;
                end
                else if (take && win_lvl == 3'(i))
                begin
                    pending_request_register[i] <= 1'b0;
                end
                else if (level_mode && !req_sync[i])
                begin
                    pending_request_register[i] <= 1'b0;
                end
            end
        end
    end

    // ******************************************************************
    // In-service set
    // ******************************************************************

    // Acknowledge sets, end-of-service clears; automatic mode never sets
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || is_fiw)
        begin
            in_service_register <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (take && !aeoi && win_lvl == 3'(i))
                begin
                    in_service_register[i] <= 1'b1;
                end
                else if (is_eos && (eos_code == `PIC_EOS_NONSPEC || eos_code == `PIC_EOS_ROT_NS)
                         && top[3] && ns_lvl == 3'(i))
                begin
                    in_service_register[i] <= 1'b0;
                end
                else if (is_eos && (eos_code == `PIC_EOS_SPEC || eos_code == `PIC_EOS_ROT_SP)
                         && bus_in.wdata[2:0] == 3'(i))
                begin
                    in_service_register[i] <= 1'b0;
                end
            end
        end
    end

    // ******************************************************************
    // Host-facing outputs
    // ******************************************************************

    // Interrupt line; vector of the winner, level 7 when no request wins
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            int_out          <= 1'b0;
            vector_out       <= 8'h00;
            vector_valid_out <= 1'b0;
            cascade_map_out  <= '0;
        end
        else
        begin
            int_out          <= win_ok && !ack_in && !poll_rd;
            vector_valid_out <= ack_in;
            if (ack_in)
            begin
                vector_out <= {type_base, win_ok ? win_lvl : 3'h7};
            end
            cascade_map_out <= NUM_IN'(casc);
        end
    end

    // Mask needs no select; poll answer takes priority on the command port
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            rd_data_out <= 8'h00;
        end
        else if (bus_in.rd && bus_in.addr == `PIC_ADDR_DATA)
        begin
            rd_data_out <= request_mask_register;
        end
        else if (poll_rd)
        begin
            rd_data_out <= {win_ok, 4'h0, win_ok ? win_lvl : 3'h0};
        end
        else if (bus_in.rd)
        begin
            rd_data_out <= read_isr ? in_service_register : pending_request_register;
        end
        else
        begin
            rd_data_out <= 8'h00;
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_spec_eos;
        is_eos && eos_code == `PIC_EOS_SPEC && !take;
    endsequence

    chk_ack_sets_isr: assert property (take && !aeoi |=> in_service_register[$past(win_lvl)] == 1'b1)
        else $error("acknowledge did not set in-service bit");
    chk_ack_vector: assert property (ack_in && win_ok |=> vector_valid_out
        && vector_out == {type_base, $past(win_lvl)})
        else $error("wrong type number on acknowledge");
    chk_spec_eos: assert property (s_spec_eos |=> !in_service_register[$past(bus_in.wdata[2:0])])
        else $error("specific end-of-service left bit set");
    chk_set_prio: assert property (is_eos && eos_code == `PIC_EOS_SETPRI
        |=> lowest == $past(bus_in.wdata[2:0]))
        else $error("set-priority not applied");
    chk_smm_end: assert property (is_rsc && bus_in.wdata[6:5] == 2'b10 |=> !special_mask_select_bit)
        else $error("special mask mode did not end");
    chk_mask_read: assert property (bus_in.rd && bus_in.addr == `PIC_ADDR_DATA
        |=> rd_data_out == $past(request_mask_register))
        else $error("mask read mismatch");
    chk_nest_block: assert property (!win_ok && !is_fiw ##1 !win_ok |-> !int_out)
        else $error("interrupt raised without a better request");
    chk_aeoi_isr: assert property (take && aeoi && !bus_in.wr |=> in_service_register == $past(in_service_register))
        else $error("automatic end-of-service touched in-service set");
    chk_poll_level: assert property (poll_rd && win_ok
        |=> rd_data_out == {5'h10, $past(win_lvl)} && in_service_register != 8'h00 || aeoi)
        else $error("poll answer wrong");
endmodule
`default_nettype wire

// ===== testbench/pic_host_model.sv
// Host model: acknowledges the interrupt line after a chosen delay
`timescale 1ns/1ns
`default_nettype none
module pic_host_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       int_in,
    input  wire logic       en_in,
    input  wire logic [3:0] delay_in,
    output logic            ack_out
);
    logic [3:0] wait_cnt;

    // One ack per raise; the edge after an ack still shows a stale line, so skip it
    always_ff @(posedge clk_in)
    begin
        if (rst_in || ack_out)
        begin
            ack_out  <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (int_in && en_in)
        begin
            if (wait_cnt >= delay_in)
                ack_out <= 1'b1;
            wait_cnt <= wait_cnt + 4'h1;
        end
        else
            wait_cnt <= 4'h0;
    end
endmodule
`default_nettype wire

// ===== testbench/tb_pic_unit.sv
// Self-checking bench for the priority interrupt unit
`timescale 1ns/1ns
`default_nettype none
module tb_pic_unit;
    import pic_pkg::*;
    // ****************
    // Signals
    // ****************
    logic       sys_clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    pic_bus_s   bus        = '0;
    logic [7:0] req        = 8'h00;
    logic       host_en    = 1'b1;
    logic [3:0] host_dly   = 4'h0;
    logic       ack;
    logic [7:0] rd_data;
    logic [7:0] vec;
    logic [7:0] cmap;
    logic       int_l;
    logic       vec_ok;
    logic [4:0] base;
    logic [2:0] lowest;
    logic [2:0] w;
    logic [7:0] got;
    logic [7:0] m;
    logic [7:0] codes [4] = '{8'h20, 8'h60, 8'ha0, 8'he0};
    int         fails       = 0;
    int         check_count = 0;
    int         cycles      = 0;

    pic_unit #(.NUM_IN(8)) DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .bus_in(bus), .req_in(req), .ack_in(ack), .rd_data_out(rd_data),
        .int_out(int_l), .vector_out(vec), .vector_valid_out(vec_ok),
        .cascade_map_out(cmap));
    pic_host_model host (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .int_in(int_l),
        .en_in(host_en), .delay_in(host_dly), .ack_out(ack));

    always #5 sys_clk_in = ~sys_clk_in;

    // Cut a hang short well above the expected run length
    always @(posedge sys_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fails++;
            wrap_up();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge sys_clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic a, output logic [7:0] d);
        @(posedge sys_clk_in);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        @(negedge sys_clk_in);
        d = rd_data;
    endtask

    task automatic pins(input logic [7:0] p);
        @(posedge sys_clk_in);
        req <= p;
    endtask

    task automatic wait_vec(input logic [2:0] lvl);
        int n;
        n = 0;
        while (vec_ok !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        check("valid", {7'h00, vec_ok}, 8'h01);
        check("vector", vec, {base, lvl});
        @(negedge sys_clk_in);
    endtask

    task automatic quiet(input int n);
        repeat (n)
        begin
            @(negedge sys_clk_in);
            check("int", {7'h00, int_l}, 8'h00);
        end
    endtask

    // Winner of a pattern under the current ranking
    function automatic logic [2:0] top(input logic [7:0] p);
        logic [2:0] b;
        top = lowest + 3'h1;
        for (int k = 8; k >= 1; k--)
        begin
            b = lowest + 3'(k);
            if (p[b])
                top = b;
        end
    endfunction

    // Service a pattern level by level; specific codes carry the level
    // Rotation only moves the bottom to levels already served, so the
    // service order stays the one ranked from the starting bottom level
    task automatic run(input logic [7:0] pat, input logic [7:0] end_of_service_command);
        logic [2:0] b;
        logic [2:0] start;
        int k;
        start = lowest;
        pins(pat);
        for (k = 1; k <= 8; k++)
        begin
            b = start + 3'(k);
            if (pat[b])
            begin
                wait_vec(b);
                wr(1'b0, end_of_service_command | (end_of_service_command[6] ? {5'h00, b} : 8'h00));
                if (end_of_service_command[7])
                    lowest = b;
            end
        end
        quiet(8);
        pins(8'h00);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        void'($urandom(78933));
        base = 5'($urandom);
        lowest = 3'h7;
        repeat (5) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(negedge sys_clk_in);
        check("idle", {int_l, vec_ok, cmap[5:0]}, 8'h00);
        wr(1'b0, 8'h11);
        wr(1'b1, {base, 3'h0});
        wr(1'b1, 8'h20);
        wr(1'b1, 8'h11);
        check("cascade", cmap, 8'h20);
        rd(1'b1, got);
        check("mask", got, 8'h00);
        // Every end-of-service kind, with set-priority between rounds
        for (int i = 0; i < 16; i++)
        begin
            if (i % 4 == 2)
            begin
                lowest = 3'($urandom);
                wr(1'b0, {5'h18, lowest});
            end
            host_dly <= 4'($urandom % 6);
            run(8'($urandom), codes[i % 4]);
        end
        // Pending set, poll as acknowledge, persistent selection
        host_en <= 1'b0;
        pins(8'h24);
        repeat (6) @(posedge sys_clk_in);
        rd(1'b0, got);
        check("pending", got, 8'h24);
        w = top(8'h24);
        wr(1'b0, 8'h0c);
        rd(1'b0, got);
        check("poll", got, {1'b1, 4'h0, w});
        wr(1'b0, 8'h0b);
        repeat (2)
        begin
            rd(1'b0, got);
            check("service", got, 8'h01 << w);
        end
        wr(1'b0, 8'h0a);
        rd(1'b0, got);
        check("pending", got, 8'h24 & ~(8'h01 << w));
        wr(1'b0, {5'h0c, w});
        host_en <= 1'b1;
        wait_vec(w == 3'h2 ? 3'h5 : 3'h2);
        wr(1'b0, 8'h20);
        pins(8'h00);
        // Nesting: higher preempts, lower held off, special mask
        lowest = 3'h7;
        wr(1'b0, 8'hc7);
        pins(8'h40);
        wait_vec(3'h6);
        pins(8'h44);
        wait_vec(3'h2);
        pins(8'hc4);
        quiet(8);
        wr(1'b0, 8'h20);
        quiet(8);
        wr(1'b1, 8'h40);
        wr(1'b0, 8'h68);
        wait_vec(3'h7);
        wr(1'b0, 8'h48);
        wr(1'b0, 8'h67);
        wr(1'b0, 8'h66);
        wr(1'b1, 8'h00);
        pins(8'h00);
        // Cascaded input may interrupt again while in service
        pins(8'h20);
        wait_vec(3'h5);
        pins(8'h00);
        pins(8'h20);
        wait_vec(3'h5);
        wr(1'b0, 8'h65);
        pins(8'h00);
        // Mask store and masked request
        repeat (4)
        begin
            m = 8'($urandom);
            wr(1'b1, m);
            rd(1'b1, got);
            check("mask", got, m);
        end
        wr(1'b1, 8'h01);
        pins(8'h01);
        quiet(8);
        wr(1'b1, 8'h00);
        wait_vec(3'h0);
        wr(1'b0, 8'h20);
        pins(8'h00);
        // Three-word init with automatic end-of-service
        wr(1'b0, 8'h13);
        wr(1'b1, {base, 3'h0});
        wr(1'b1, 8'h03);
        pins(8'h10);
        wait_vec(3'h4);
        wr(1'b0, 8'h0b);
        rd(1'b0, got);
        check("service", got, 8'h00);
        pins(8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
